// ---- hdl/light_map.vh ----
/*
  Constants for the ambient light result and configuration register block:
  register offsets, field positions, reset values and conversion timing.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef LIGHT_MAP_VH
`define LIGHT_MAP_VH

// ==========================================================================
// Register offsets
`define OFS_LIGHT_RESULT 8'h00
`define OFS_MEAS_CONFIG 8'h01

// ==========================================================================
// Result layout and reset
`define RES_EXP_HI 15
`define RES_EXP_LO 12
`define RES_MANT_HI 11
`define RES_MANT_LO 0
`define RES_RESET 16'h0000

// ==========================================================================
// Configuration layout and reset
`define CFG_RESET 16'hc810
`define CFG_WR_MASK 16'hfe1f
`define CFG_RANGE_HI 15
`define CFG_RANGE_LO 12
`define CFG_CONV_TIME 11
`define CFG_MODE_HI 10
`define CFG_MODE_LO 9
`define CFG_OVERFLOW 8
`define CFG_CONV_READY 7
`define CFG_HIGH_FLAG 6
`define CFG_LOW_FLAG 5
`define CFG_LATCH 4
`define CFG_POLARITY 3
`define CFG_EXP_MASK 2
`define CFG_FAULT_HI 1
`define CFG_FAULT_LO 0

// ==========================================================================
// Range and mode codes
`define RANGE_AUTO 4'hc
`define MODE_SHUTDOWN 2'h0
`define MODE_SINGLE 2'h1

// ==========================================================================
// Conversion timing
`define CLK_CYC_PER_MS 100000
`define CONV_SHORT_MS 100
`define CONV_LONG_MS 800
`define CONV_CNT_W 27

`endif

// ---- hdl/conv_timer.v ----
/*
  Conversion interval timer: counts one integration period and pulses done.
  Assumes start is a one-cycle pulse that restarts the count from zero.
*/
`timescale 1ns/100ps
`include "light_map.vh"

module conv_timer #(
  parameter SHORT_CYC = `CONV_SHORT_MS * `CLK_CYC_PER_MS,
  parameter LONG_CYC = `CONV_LONG_MS * `CLK_CYC_PER_MS
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Control
  input wire start_i,
  input wire abort_i,
  input wire long_sel_i,
  // Status
  output reg busy_o,
  output reg done_o
);

  reg [`CONV_CNT_W-1:0] count_q;
  reg [`CONV_CNT_W-1:0] limit_q;

  // ==========================================================================
  // Interval count
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= {`CONV_CNT_W{1'b0}};
      limit_q <= {`CONV_CNT_W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count_q <= {`CONV_CNT_W{1'b0}};
        // Period fixed at start so a later change cannot stretch it
        limit_q <= long_sel_i ? LONG_CYC[`CONV_CNT_W-1:0] : SHORT_CYC[`CONV_CNT_W-1:0];
        busy_o <= 1'b1;
      end else if (abort_i) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        if (count_q == limit_q - {{(`CONV_CNT_W-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count_q <= count_q + {{(`CONV_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ---- hdl/result_capture.v ----
/*
  Result word holder: captures exponent and mantissa in one write.
  Assumes capture_i is a one-cycle pulse with exponent and mantissa valid.
*/
`timescale 1ns/100ps
`include "light_map.vh"

module result_capture (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Capture
  input wire capture_i,
  input wire [3:0] exp_i,
  input wire [11:0] mant_i,
  // Stored word
  output reg [15:0] result_o
);

  // ==========================================================================
  // Single register for both fields
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_o <= `RES_RESET;
    end else if (capture_i) begin
      result_o <= {exp_i, mant_i};
    end
  end

endmodule

// ---- hdl/light_result_config_regs.v ----
/*
  Result and configuration register front end of an ambient light meter.
  Holds the latest conversion as exponent and mantissa, holds the
  configuration word, and sequences conversions of the front end.
  Assumes a register access port on the same clock (bus framing sits
  outside), and a converter on the same clock that presents its mantissa,
  auto-range exponent, overflow and limit results while meas_valid_i is high.
  Every register and output moves on the rising clock edge only; reset is
  asynchronous and active low. The integration interval is counted here in
  clock cycles, so SHORT_CYC and LONG_CYC must match the clock rate in use.
  Converter results are only looked at on the cycle the interval ends, so
  the converter must hold them steady until then.
*/
`timescale 1ns/100ps
`include "light_map.vh"

module light_result_config_regs #(
  parameter SHORT_CYC = `CONV_SHORT_MS * `CLK_CYC_PER_MS,
  parameter LONG_CYC = `CONV_LONG_MS * `CLK_CYC_PER_MS
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Register access
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // Converter front end
  input wire meas_valid_i,
  input wire [11:0] meas_mant_i,
  input wire [3:0] meas_auto_exp_i,
  input wire meas_overflow_i,
  input wire limit_high_i,
  input wire limit_low_i,
  output reg conv_active_o,
  output reg [3:0] conv_range_o,
  output reg conv_long_o
);

  // ==========================================================================
  // State
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] config_q;
  reg start_q;
  reg [3:0] done_exp;
  reg [11:0] done_mant;

  // Next values
  reg start_d;
  reg [15:0] config_d;
  reg [15:0] rdata_d;
  reg active_d;
  reg [3:0] range_d;
  reg long_d;

  wire [15:0] result_word;
  wire timer_done;
  wire start_go;
  wire shot_end;
  wire cfg_wr;
  wire cfg_rd;
  wire [15:0] cfg_new;
  wire [1:0] mode_now;
  wire [3:0] range_now;
  wire conv_done;

  // ==========================================================================
  // Helpers
  function mode_runs;
    input [1:0] mode;
    begin
      mode_runs = (mode != `MODE_SHUTDOWN);
    end
  endfunction

  function mode_repeats;
    input [1:0] mode;
    begin
      // Both remaining codes mean continuous
      mode_repeats = (mode != `MODE_SHUTDOWN) && (mode != `MODE_SINGLE);
    end
  endfunction

  // Unmapped offsets read as zero so a stray poll never shows stale data
  function [15:0] read_word;
    input [7:0] addr;
    input [15:0] result;
    input [15:0] cfg_word;
    begin
      case (addr)
        `OFS_LIGHT_RESULT: begin
          read_word = result;
        end
        `OFS_MEAS_CONFIG: begin
          read_word = cfg_word;
        end
        default: begin
          read_word = 16'h0000;
        end
      endcase
    end
  endfunction

  function [3:0] report_exp;
    input [3:0] range;
    input mask_en;
    input [3:0] auto_exp;
    begin
      if (range == `RANGE_AUTO) begin
        report_exp = auto_exp;
      end else if (mask_en && (range < `RANGE_AUTO)) begin
        report_exp = 4'h0;
      end else begin
        report_exp = range;
      end
    end
  endfunction

  assign cfg_wr = reg_wr_i && (reg_addr_i == `OFS_MEAS_CONFIG);
  assign cfg_rd = reg_rd_i && (reg_addr_i == `OFS_MEAS_CONFIG);
  // Read-only flag bits keep their own value on a write
  assign cfg_new = (reg_wdata_i & `CFG_WR_MASK) | (config_q & ~`CFG_WR_MASK);
  assign mode_now = config_q[`CFG_MODE_HI:`CFG_MODE_LO];
  assign range_now = config_q[`CFG_RANGE_HI:`CFG_RANGE_LO];
  // A finish landing with a write is dropped: the write aborted it
  assign conv_done = timer_done && meas_valid_i && !cfg_wr;
  // A start pulse meeting a write yields: that write restarts or stops it
  assign start_go = start_q && !cfg_wr;
  assign shot_end = timer_done && !cfg_wr && (mode_now == `MODE_SINGLE);

  // ==========================================================================
  // Result exponent selection
  always @* begin
    done_exp = report_exp(range_now, config_q[`CFG_EXP_MASK], meas_auto_exp_i);
    done_mant = meas_mant_i;
  end

  // ==========================================================================
  // Sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_go) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (cfg_wr) begin
          state_d = ST_IDLE;
        end else if (timer_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        // An illegal code falls back to idle
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
    end
  end

  // ==========================================================================
  // Start request
  always @* begin
    start_d = 1'b0;
    if (cfg_wr) begin
      // New conversion only if the written mode asks for one
      start_d = mode_runs(cfg_new[`CFG_MODE_HI:`CFG_MODE_LO]);
    end else if (timer_done && mode_repeats(mode_now)) begin
      // Continuous mode queues the next run straight away
      start_d = 1'b1;
    end
  end

  // ==========================================================================
  // Configuration next value
  always @* begin
    config_d = config_q;
    if (cfg_wr) begin
      config_d = cfg_new;
    end
    // Single shot returns itself to shutdown when its run ends
    if (shot_end) begin
      config_d[`CFG_MODE_HI:`CFG_MODE_LO] = `MODE_SHUTDOWN;
    end
    // Ready flag: a read clears, but a finish in the same cycle wins
    if (cfg_rd) begin
      config_d[`CFG_CONV_READY] = 1'b0;
    end
    if (conv_done) begin
      config_d[`CFG_CONV_READY] = 1'b1;
      config_d[`CFG_OVERFLOW] = meas_overflow_i;
    end
    // Limit flags: transparent follow, or sticky until a read when latched
    if (config_q[`CFG_LATCH]) begin
      if (cfg_rd) begin
        config_d[`CFG_HIGH_FLAG] = 1'b0;
        config_d[`CFG_LOW_FLAG] = 1'b0;
      end
      if (conv_done && limit_high_i) begin
        config_d[`CFG_HIGH_FLAG] = 1'b1;
      end
      if (conv_done && limit_low_i) begin
        config_d[`CFG_LOW_FLAG] = 1'b1;
      end
    end else if (conv_done) begin
      config_d[`CFG_HIGH_FLAG] = limit_high_i;
      config_d[`CFG_LOW_FLAG] = limit_low_i;
    end
  end

  // ==========================================================================
  // Configuration word
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_q <= `CFG_RESET;
    end else begin
      config_q <= config_d;
    end
  end

  // ==========================================================================
  // Register reads
  // Data holds until the next read
  always @* begin
    rdata_d = reg_rdata_o;
    if (reg_rd_i) begin
      rdata_d = read_word(reg_addr_i, result_word, config_q);
    end
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= rdata_d;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ==========================================================================
  // Front end controls
  // Copies are registered so the front end never sees a half-written word
  always @* begin
    active_d = (state_d == ST_CONV);
    range_d = range_now;
    long_d = config_q[`CFG_CONV_TIME];
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_active_o <= 1'b0;
      conv_range_o <= `RANGE_AUTO;
      conv_long_o <= 1'b1;
    end else begin
      conv_active_o <= active_d;
      conv_range_o <= range_d;
      conv_long_o <= long_d;
    end
  end

  // ==========================================================================
  // Submodules
  conv_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .start_i(start_go),
    .abort_i(cfg_wr),
    .long_sel_i(config_q[`CFG_CONV_TIME]),
    .busy_o(),
    .done_o(timer_done)
  );

  result_capture u_result (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .capture_i(conv_done),
    .exp_i(done_exp),
    .mant_i(done_mant),
    .result_o(result_word)
  );

endmodule

// ---- bench/light_result_config_regs_props.sv ----
/* Port checker for the light result and configuration block.
   Assumes one clock and bind onto the block top. */
`timescale 1ns/100ps
module light_result_config_regs_props #(
  parameter SHORT_CYC = 20,
  parameter LONG_CYC = 40
) (
  // Watched ports
  input wire clock_i,
  input wire rstn_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire conv_active_o,
  input wire [3:0] conv_range_o,
  input wire conv_long_o
);
  // ======
  // Helpers
  wire cfg_wr = reg_wr_i && reg_addr_i == 8'h01;
  reg [15:0] wd_q;
  reg [31:0] act_q;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wd_q <= 16'hc810;
      act_q <= 32'h0;
    end else begin
      if (cfg_wr) begin
        wd_q <= reg_wdata_i;
      end
      act_q <= (conv_active_o && !cfg_wr) ? act_q + 32'h1 : 32'h0;
    end
  end
  // ======
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("stray read valid");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h01 |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (reg_rd_i && reg_addr_i == 8'h01 && !cfg_wr |=>
    reg_rdata_o[15:11] == wd_q[15:11] && reg_rdata_o[4:0] == wd_q[4:0])
    else $error("config readback wrong");
  a_range_copy: assert property (cfg_wr ##1 (!cfg_wr)[*2] |->
    conv_range_o == wd_q[15:12] && conv_long_o == wd_q[11])
    else $error("range copy stale");
  a_write_starts: assert property (cfg_wr && reg_wdata_i[10:9] != 2'h0 ##1 !cfg_wr |-> ##1 conv_active_o)
    else $error("conversion not started");
  a_write_aborts: assert property (cfg_wr && reg_wdata_i[10:9] == 2'h0 |-> ##[1:2] !conv_active_o)
    else $error("conversion not aborted");
  a_conv_length: assert property (conv_active_o && wd_q[10:9] == 2'h1 |->
    act_q <= (conv_long_o ? LONG_CYC : SHORT_CYC) + 4)
    else $error("conversion too long");
  c_start: cover property (cfg_wr ##2 conv_active_o);
  c_finish: cover property ($fell(conv_active_o));
  c_result_read: cover property (reg_rd_i && reg_addr_i == 8'h00 ##1 reg_rvalid_o);
endmodule

bind light_result_config_regs light_result_config_regs_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk (
  .clock_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .conv_active_o, .conv_range_o, .conv_long_o);

// ---- bench/conv_front_model.sv ----
/* Behavioural converter front end facing the register block.
   Assumes the block raises its active flag for each conversion. */
`timescale 1ns/100ps
module conv_front_model (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Control; slow keeps valid low so no result is captured
  input wire conv_active_i,
  input wire slow_i,
  // Results
  output reg meas_valid_o,
  output reg [11:0] meas_mant_o,
  output reg [3:0] meas_auto_exp_o,
  output reg meas_overflow_o,
  output reg limit_high_o,
  output reg limit_low_o
);
  integer seed = 69168;
  reg act_q;
  reg [31:0] rnd;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_q <= 1'b0;
      meas_valid_o <= 1'b0;
      {meas_overflow_o, limit_high_o, limit_low_o, meas_auto_exp_o, meas_mant_o} <= 19'h0;
    end else begin
      act_q <= conv_active_i;
      meas_valid_o <= conv_active_i && !slow_i;
      if (conv_active_i && !act_q) begin
        rnd = $random(seed);
        meas_mant_o <= rnd[11:0];
        meas_auto_exp_o <= rnd[15:12] % 4'hc;
        {meas_overflow_o, limit_high_o, limit_low_o} <= rnd[18:16];
      end
    end
  end
endmodule

// ---- bench/light_result_config_regs_bench.sv ----
/* Self-checking bench for the light result and configuration block.
   Assumes the design files and the converter model are compiled first. */
`timescale 1ns/100ps
module light_result_config_regs_bench;
  localparam SHORT_CYC = 20;
  localparam LONG_CYC = 40;
  reg clock_i = 1'b0;
  reg rstn_i = 1'b0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg slow_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [15:0] reg_wdata_i = 16'h0000;
  wire [15:0] reg_rdata_o;
  wire reg_rvalid_o, conv_active_o, conv_long_o, valid, ovf, lim_hi, lim_lo;
  wire [3:0] conv_range_o, auto_exp;
  wire [11:0] mant;
  integer seed = 69168;
  integer error_cnt = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i, n, m;
  reg [15:0] rd, w;
  reg [3:0] xe, mk;
  reg [15:0] res = 16'h0000;
  light_result_config_regs #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) DUT (
    .clock_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .meas_valid_i(valid), .meas_mant_i(mant), .meas_auto_exp_i(auto_exp),
    .meas_overflow_i(ovf), .limit_high_i(lim_hi), .limit_low_i(lim_lo),
    .conv_active_o, .conv_range_o, .conv_long_o);
  conv_front_model conv (.clock_i, .rstn_i, .conv_active_i(conv_active_o), .slow_i,
    .meas_valid_o(valid), .meas_mant_o(mant), .meas_auto_exp_o(auto_exp),
    .meas_overflow_o(ovf), .limit_high_o(lim_hi), .limit_low_o(lim_lo));
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  // ======
  // Tasks
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input string name, input [15:0] exp, input [15:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge clock_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
    end
  endtask
  task rdr(input [7:0] a);
    begin
      @(negedge clock_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge clock_i);
      reg_rd_i = 1'b0;
      check("rvalid", 16'h1, {15'h0, reg_rvalid_o});
      rd = reg_rdata_o;
    end
  endtask
  // Bounded waits: start, then end of the conversion
  task run_conv;
    begin
      n = 0;
      while (conv_active_o !== 1'b1 && n < 5) begin
        @(negedge clock_i);
        n = n + 1;
      end
      n = 0;
      while (conv_active_o === 1'b1 && n < 200) begin
        @(negedge clock_i);
        n = n + 1;
      end
    end
  endtask
  function [3:0] exp_of(input [3:0] r, input mk, input [3:0] a);
    exp_of = (r == 4'hc) ? a : (mk ? 4'h0 : r);
  endfunction
  // Host view: hundredths of a lux, with the programmed range added when masked
  function [26:0] lux_of(input [15:0] r, input [3:0] add);
    lux_of = {15'h0, r[11:0]} << (r[15:12] | add);
  endfunction
  // ======
  // Sequence
  initial begin
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    rdr(8'h01);
    check("config", 16'hc810, rd);
    rdr(8'h00);
    check("result", 16'h0000, rd);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      w = $random(seed);
      w = w & 16'hf9ff;
      wr(8'h01, w);
      wr(8'h00, ~w);
      wr(8'h05, w);
      rdr(8'h01);
      check("config", w & 16'hf81f, rd);
      rdr(8'h00);
      check("result", 16'h0000, rd);
      rdr(8'h07);
      check("unmapped", 16'h0000, rd);
    end
    $display("access test done");
    for (i = 0; i < 13; i = i + 1) begin
      w = $random(seed);
      w = {i[3:0], w[11], 2'h1, 4'h0, w[4:0]};
      slow_i = (i == 5);
      wr(8'h01, w);
      run_conv;
      m = w[11] ? LONG_CYC : SHORT_CYC;
      check("long", {15'h0, w[11]}, {15'h0, conv_long_o});
      check("length", 16'h1, {15'h0, n >= m - 1 && n <= m + 2});
      if (!slow_i)
        res = {exp_of(w[15:12], w[2], auto_exp), mant};
      rdr(8'h00);
      check("result", res, rd);
      xe = (w[15:12] == 4'hc) ? auto_exp : w[15:12];
      mk = (w[2] && w[15:12] != 4'hc) ? w[15:12] : 4'h0;
      if (!slow_i)
        check("lux", 16'h1, {15'h0, lux_of(rd, mk) == ({15'h0, mant} << xe)});
      rdr(8'h01);
      check("mode", 16'h0, {14'h0, rd[10:9]});
      if (!slow_i)
        check("config", {w[15:11], 2'h0, ovf, 3'h4, w[4:0]}, rd & 16'hff9f);
      if (!slow_i && !w[4])
        check("flags", {12'h0, ovf, 1'b1, lim_hi, lim_lo}, {12'h0, rd[8:5]});
    end
    $display("single shot test done");
    wr(8'h01, 16'h3200);
    repeat (6) @(negedge clock_i);
    wr(8'h01, 16'h3000);
    repeat (SHORT_CYC + 5) @(negedge clock_i);
    check("active", 16'h0, {15'h0, conv_active_o});
    rdr(8'h00);
    check("result", res, rd);
    wr(8'h01, 16'h3200);
    repeat (6) @(negedge clock_i);
    wr(8'h01, 16'h3600);
    repeat (3) @(negedge clock_i);
    check("active", 16'h1, {15'h0, conv_active_o});
    run_conv;
    check("length", 16'h1, {15'h0, n >= SHORT_CYC - 2 && n <= SHORT_CYC});
    res = {4'h3, mant};
    rdr(8'h00);
    check("result", res, rd);
    rdr(8'h01);
    check("mode", 16'h3, {14'h0, rd[10:9]});
    wr(8'h01, 16'h3000);
    $display("abort test done");
    end_sim;
  end
endmodule
